// File: rtl/pcmx_law_xlate.sv
`timescale 1ns/1ps
module pcmx_law_xlate (
   input  wire logic       voice_data,
   input  wire logic [1:0] input_law_select,
   input  wire logic [1:0] output_law_select,
   input  wire logic [7:0] octet_in,
   output logic      [7:0] octet_out
);

   localparam logic [15:0] MU_CLIP = 16'h7f7b;
   localparam logic [15:0] MU_BIAS = 16'h0084;
   localparam logic [15:0] A_KNEE  = 16'h0100;

   // Decode a raw (uninverted) code to a 16-bit magnitude.
   function automatic logic [15:0] decode_mag(input logic is_mu, input logic [6:0] raw);
      logic [15:0] t;
      t = 16'h0000;
      if (is_mu) begin
         t = ({9'h000, raw[3:0], 3'h0} + MU_BIAS) << raw[6:4];
         t = t - MU_BIAS;
      end else begin
         t = {8'h00, raw[3:0], 4'h8};
         if (raw[6:4] != 3'h0) begin
            t = t + A_KNEE;
         end
         if (raw[6:4] > 3'h1) begin
            t = t << (raw[6:4] - 3'h1);
         end
      end
      decode_mag = t;
   endfunction

   // Encode a 16-bit magnitude back into segment and step bits.
   function automatic logic [6:0] encode_mag(input logic is_mu, input logic [15:0] mag);
      logic [15:0] m;
      logic [2:0]  seg;
      logic [15:0] sh;
      m   = mag;
      seg = 3'h0;
      if (is_mu) begin
         if (m > MU_CLIP) begin
            m = MU_CLIP;
         end
         m = m + MU_BIAS;
      end
      for (int b = 8; b <= 14; b++) begin
         if (m[b]) begin
            seg = 3'(b - 7);
         end
      end
      if (!is_mu && m < A_KNEE) begin
         sh = m >> 4;
      end else begin
         // Widened sum: the top segments need shifts of 8 to 10.
         sh = m >> ({1'b0, seg} + 4'h3);
      end
      encode_mag = {seg, sh[3:0]};
   endfunction

   logic [7:0]  raw_in;
   logic        neg;
   logic [15:0] mag;
   logic [6:0]  raw_out;
   logic        in_mu;
   logic        out_mu;

   always_comb begin
      in_mu   = input_law_select[0];
      out_mu  = output_law_select[0];
      raw_in  = octet_in ^ pcmx_pkg::voice_mask(input_law_select);
      neg     = in_mu ? raw_in[7] : ~raw_in[7];
      mag     = decode_mag(in_mu, raw_in[6:0]);
      raw_out = encode_mag(out_mu, mag);
      if (input_law_select == output_law_select) begin
         octet_out = octet_in;
      end else if (voice_data) begin
         octet_out = octet_in ^ pcmx_pkg::data_mask(input_law_select)
                   ^ pcmx_pkg::data_mask(output_law_select);
      end else if (in_mu == out_mu) begin
         octet_out = octet_in ^ pcmx_pkg::voice_mask(input_law_select)
                   ^ pcmx_pkg::voice_mask(output_law_select);
      end else begin
         octet_out = {(out_mu ? neg : ~neg), raw_out}
                   ^ pcmx_pkg::voice_mask(output_law_select);
      end
   end

endmodule // pcmx_law_xlate

// File: rtl/pcmx_pkg.sv
package pcmx_pkg;

   // Register map on the 14-bit address, 16-bit data microprocessor port.
   localparam int          ADDR_W        = 14;
   localparam int          DATA_W        = 16;
   localparam int          STREAMS       = 32;
   localparam int          STREAM_W      = 5;
   localparam int          CHAN_W        = 8;
   localparam int          QFC_USED_W    = 12;
   localparam logic [13:0] QFC_BASE      = 14'h0100;
   localparam int          QFC_IDX_W     = 5;
   localparam logic [13:0] STAT_ADDR     = 14'h0120;
   localparam logic [11:0] QFC_RESET     = 12'h000;

   // Quadrant force code fields: quadrant y occupies bits 3y+2 .. 3y.
   localparam int          QCODE_W       = 3;
   localparam int          FORCE_EN_BIT  = 2;
   localparam int          FORCE_MSB_BIT = 1;
   localparam int          FORCE_VAL_BIT = 0;

   // Upper connection memory entry fields.
   localparam int          CMH_W         = 5;
   localparam int          VD_BIT        = 4;
   localparam int          ILAW_LSB      = 2;
   localparam int          OLAW_LSB      = 0;

   // Input stream rate codes.
   localparam logic [1:0]  RATE_2M       = 2'h0;
   localparam logic [1:0]  RATE_4M       = 2'h1;
   localparam logic [1:0]  RATE_8M       = 2'h2;
   localparam logic [1:0]  RATE_16M      = 2'h3;

   // Law codes and the inversion each one applies to the raw code.
   localparam logic [1:0]  LAW_A         = 2'h0;
   localparam logic [1:0]  LAW_MU        = 2'h1;
   localparam logic [1:0]  LAW_A_PLAIN   = 2'h2;
   localparam logic [1:0]  LAW_MU_PLAIN  = 2'h3;
   localparam logic [7:0]  INV_NONE      = 8'h00;
   localparam logic [7:0]  INV_EVEN      = 8'h55;
   localparam logic [7:0]  INV_ODD       = 8'haa;
   localparam logic [7:0]  INV_ALL       = 8'hff;
   localparam logic [7:0]  INV_SIGN      = 8'h80;

   function automatic logic [7:0] voice_mask(input logic [1:0] law);
      unique case (law)
         LAW_A:       voice_mask = INV_EVEN;
         LAW_MU:      voice_mask = INV_ALL;
         LAW_A_PLAIN: voice_mask = INV_NONE;
         default:     voice_mask = INV_SIGN;
      endcase
   endfunction

   function automatic logic [7:0] data_mask(input logic [1:0] code);
      unique case (code)
         2'h0:    data_mask = INV_NONE;
         2'h1:    data_mask = INV_EVEN;
         2'h2:    data_mask = INV_ODD;
         default: data_mask = INV_ALL;
      endcase
   endfunction

endpackage

// File: rtl/pcmx_quad_law.sv
`timescale 1ns/1ps
module pcmx_quad_law (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        cpu_cs,
   input  wire logic        cpu_wr,
   input  wire logic [13:0] cpu_addr,
   input  wire logic [15:0] cpu_wdata,
   output logic      [15:0] cpu_rdata,
   output logic             cpu_ack,
   input  wire logic        in_valid,
   input  wire logic [4:0]  in_stream,
   input  wire logic [7:0]  in_chan,
   input  wire logic [1:0]  in_rate,
   input  wire logic [7:0]  in_octet,
   output logic             store_valid,
   output logic [4:0]       store_stream,
   output logic [7:0]       store_chan,
   output logic [7:0]       store_octet,
   input  wire logic        out_valid,
   input  wire logic        out_msg_mode,
   input  wire logic [7:0]  out_data_octet,
   input  wire logic [7:0]  out_msg_octet,
   input  wire logic [4:0]  conn_mem_upper_entry,
   output logic             tx_valid,
   output logic [7:0]       tx_octet
);

   // Quadrant number of a channel: the top two bits of the channel index
   // for the stream's frame length.
   function automatic logic [1:0] quad_of(input logic [1:0] rate, input logic [7:0] chan);
      unique case (rate)
         pcmx_pkg::RATE_2M:  quad_of = chan[4:3];
         pcmx_pkg::RATE_4M:  quad_of = chan[5:4];
         pcmx_pkg::RATE_8M:  quad_of = chan[6:5];
         default:            quad_of = chan[7:6];
      endcase
   endfunction

   function automatic logic [2:0] code_of(input logic [11:0] ctrl, input logic [1:0] q);
      unique case (q)
         2'h0:    code_of = ctrl[2:0];
         2'h1:    code_of = ctrl[5:3];
         2'h2:    code_of = ctrl[8:6];
         default: code_of = ctrl[11:9];
      endcase
   endfunction

   function automatic logic [7:0] apply_force(input logic [7:0] octet, input logic [2:0] code);
      logic [7:0] o;
      o = octet;
      if (code[pcmx_pkg::FORCE_EN_BIT]) begin
         if (code[pcmx_pkg::FORCE_MSB_BIT]) begin
            o[7] = code[pcmx_pkg::FORCE_VAL_BIT];
         end else begin
            o[0] = code[pcmx_pkg::FORCE_VAL_BIT];
         end
      end
      apply_force = o;
   endfunction

   // Register port.
   logic [11:0] input_stream_quadrant_force_ctrl_q [pcmx_pkg::STREAMS];
   logic [11:0] input_stream_quadrant_force_ctrl_d [pcmx_pkg::STREAMS];
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   logic        ack_q;
   logic        ack_d;
   logic        qfc_hit;
   logic [4:0]  qfc_idx;
   logic [7:0]  last_forced_q;
   logic [7:0]  last_forced_d;

   always_comb begin
      qfc_hit = (cpu_addr[13:5] == pcmx_pkg::QFC_BASE[13:5]);
      qfc_idx = cpu_addr[4:0];
      ack_d   = cpu_cs;
      rdata_d = 16'h0000;
      for (int s = 0; s < pcmx_pkg::STREAMS; s++) begin
         input_stream_quadrant_force_ctrl_d[s] = input_stream_quadrant_force_ctrl_q[s];
      end
      if (cpu_cs && cpu_wr && qfc_hit) begin
         input_stream_quadrant_force_ctrl_d[qfc_idx] = cpu_wdata[11:0];
      end
      if (cpu_cs && !cpu_wr) begin
         if (qfc_hit) begin
            rdata_d = {4'h0, input_stream_quadrant_force_ctrl_q[qfc_idx]};
         end else if (cpu_addr == pcmx_pkg::STAT_ADDR) begin
            rdata_d = {8'h00, last_forced_q};
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int s = 0; s < pcmx_pkg::STREAMS; s++) begin
            input_stream_quadrant_force_ctrl_q[s] <= pcmx_pkg::QFC_RESET;
         end
         rdata_q <= 16'h0000;
         ack_q   <= 1'b0;
      end else begin
         input_stream_quadrant_force_ctrl_q <= input_stream_quadrant_force_ctrl_d;
         rdata_q <= rdata_d;
         ack_q   <= ack_d;
      end
   end

   assign cpu_rdata = rdata_q;
   assign cpu_ack   = ack_q;

   // Receive path: bit forcing ahead of the switch store.
   logic [1:0] in_quad;
   logic [2:0] quadrant_force_code;
   logic [7:0] forced_octet;
   logic       st_valid_q;
   logic       st_valid_d;
   logic [4:0] st_stream_q;
   logic [4:0] st_stream_d;
   logic [7:0] st_chan_q;
   logic [7:0] st_chan_d;
   logic [7:0] st_octet_q;
   logic [7:0] st_octet_d;

   always_comb begin
      in_quad             = quad_of(in_rate, in_chan);
      quadrant_force_code = code_of(input_stream_quadrant_force_ctrl_q[in_stream], in_quad);
      forced_octet        = apply_force(in_octet, quadrant_force_code);
      st_valid_d          = in_valid;
      st_stream_d         = in_valid ? in_stream : st_stream_q;
      st_chan_d           = in_valid ? in_chan : st_chan_q;
      st_octet_d          = in_valid ? forced_octet : st_octet_q;
      last_forced_d       = (in_valid && quadrant_force_code[pcmx_pkg::FORCE_EN_BIT])
                          ? forced_octet : last_forced_q;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st_valid_q    <= 1'b0;
         st_stream_q   <= 5'h00;
         st_chan_q     <= 8'h00;
         st_octet_q    <= 8'h00;
         last_forced_q <= 8'h00;
      end else begin
         st_valid_q    <= st_valid_d;
         st_stream_q   <= st_stream_d;
         st_chan_q     <= st_chan_d;
         st_octet_q    <= st_octet_d;
         last_forced_q <= last_forced_d;
      end
   end

   assign store_valid  = st_valid_q;
   assign store_stream = st_stream_q;
   assign store_chan   = st_chan_q;
   assign store_octet  = st_octet_q;

   // Transmit path: law translation on the octet read for the output channel.
   logic [7:0] sel_octet;
   logic [7:0] xl_octet;
   logic       tx_valid_q;
   logic       tx_valid_d;
   logic [7:0] tx_octet_q;
   logic [7:0] tx_octet_d;

   always_comb begin
      sel_octet  = out_msg_mode ? out_msg_octet : out_data_octet;
      tx_valid_d = out_valid;
      tx_octet_d = out_valid ? xl_octet : tx_octet_q;
   end

   pcmx_law_xlate u_xlate (
      .voice_data        (conn_mem_upper_entry[pcmx_pkg::VD_BIT]),
      .input_law_select  (conn_mem_upper_entry[pcmx_pkg::ILAW_LSB +: 2]),
      .output_law_select (conn_mem_upper_entry[pcmx_pkg::OLAW_LSB +: 2]),
      .octet_in          (sel_octet),
      .octet_out         (xl_octet)
   );

   always_ff @(posedge mclk) begin
      if (rst) begin
         tx_valid_q <= 1'b0;
         tx_octet_q <= 8'h00;
      end else begin
         tx_valid_q <= tx_valid_d;
         tx_octet_q <= tx_octet_d;
      end
   end

   assign tx_valid = tx_valid_q;
   assign tx_octet = tx_octet_q;

   // Helper copies, one cycle back, of the selected and incoming octets, the force code and the entry, read only by the checks.
   logic [7:0] chk_sel_q;
   logic [7:0] chk_in_q;
   logic [2:0] chk_code_q;
   logic [4:0] chk_cmh_q;

   always_ff @(posedge mclk) begin
      chk_sel_q  <= sel_octet;
      chk_in_q   <= in_octet;
      chk_code_q <= quadrant_force_code;
      chk_cmh_q  <= conn_mem_upper_entry;
   end

   AST_STORE_FOLLOWS: assert property (@(posedge mclk) disable iff (rst)
      in_valid |=> store_valid && store_octet[6:1] == chk_in_q[6:1])
      else $error("Stored octet does not follow the incoming octet.");

   AST_FORCE_LSB: assert property (@(posedge mclk) disable iff (rst)
      (in_valid && quadrant_force_code[2:1] == 2'b10)
      |=> store_octet[0] == chk_code_q[0] && store_octet[7] == chk_in_q[7])
      else $error("LSB force code did not set the LSB.");

   AST_FORCE_MSB: assert property (@(posedge mclk) disable iff (rst)
      (in_valid && quadrant_force_code[2:1] == 2'b11)
      |=> store_octet[7] == chk_code_q[0] && store_octet[0] == chk_in_q[0])
      else $error("MSB force code did not set the MSB.");

   AST_NO_FORCE: assert property (@(posedge mclk) disable iff (rst)
      (in_valid && !quadrant_force_code[2]) |=> store_octet == chk_in_q)
      else $error("Octet altered while the force code was off.");

   AST_SAME_LAW: assert property (@(posedge mclk) disable iff (rst)
      (out_valid && conn_mem_upper_entry[3:2] == conn_mem_upper_entry[1:0])
      |=> tx_valid && tx_octet == chk_sel_q)
      else $error("Octet changed although both laws match.");

   AST_DATA_CODE: assert property (@(posedge mclk) disable iff (rst)
      (out_valid && conn_mem_upper_entry[4])
      |=> tx_octet == (chk_sel_q ^ pcmx_pkg::data_mask(chk_cmh_q[3:2])
                                 ^ pcmx_pkg::data_mask(chk_cmh_q[1:0])))
      else $error("Data code inversion is wrong.");

   AST_A_VARIANT: assert property (@(posedge mclk) disable iff (rst)
      (out_valid && conn_mem_upper_entry == 5'h02) |=> tx_octet == (chk_sel_q ^ 8'h55))
      else $error("A-law to plain A-law did not flip the even bits.");

   AST_MU_VARIANT: assert property (@(posedge mclk) disable iff (rst)
      (out_valid && conn_mem_upper_entry == 5'h07) |=> tx_octet == (chk_sel_q ^ 8'h7f))
      else $error("Mu-law to plain mu-law did not flip the magnitude bits.");

   AST_XLAW_SIGN: assert property (@(posedge mclk) disable iff (rst)
      (out_valid && !conn_mem_upper_entry[4]
       && conn_mem_upper_entry[2] != conn_mem_upper_entry[0])
      |=> tx_valid && tx_octet[7] == chk_sel_q[7])
      else $error("Law conversion changed the sign of the sample.");

   AST_MSG_PATH: assert property (@(posedge mclk) disable iff (rst)
      (out_valid && out_msg_mode && conn_mem_upper_entry == 5'h00)
      |=> tx_octet == $past(out_msg_octet))
      else $error("Message byte not carried to the output.");

   AST_REG_ACK: assert property (@(posedge mclk) disable iff (rst)
      (cpu_cs && cpu_wr && qfc_hit) ##1 (cpu_cs && !cpu_wr && $past(cpu_addr) == cpu_addr)
      |=> cpu_ack && cpu_rdata[11:0] == $past(cpu_wdata[11:0], 2))
      else $error("Force register did not read back what was written.");

endmodule // pcmx_quad_law

// File: sim/pcmx_far_model.sv
`timescale 1ns/1ps
module pcmx_far_model (
   input  wire logic       mclk,
   input  wire logic       store_valid,
   input  wire logic [4:0] store_stream,
   input  wire logic [7:0] store_chan,
   input  wire logic [7:0] store_octet,
   input  wire logic [4:0] rd_stream,
   input  wire logic [7:0] rd_chan,
   output logic      [7:0] rd_octet
);
   // Switch data memory, one octet per input stream and channel.
   logic [7:0] mem [0:8191];

   // Unwritten places hold a pattern so that a stray read never looks settled.
   initial begin
      for (int k = 0; k < 8192; k++) begin
         mem[k] = 8'(k) ^ 8'h3c;
      end
   end

   always @(posedge mclk) begin
      if (store_valid) begin
         mem[{store_stream, store_chan}] <= store_octet;
      end
   end

   assign rd_octet = mem[{rd_stream, rd_chan}];
endmodule // pcmx_far_model

// File: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        cpu_cs = 1'b0;
   logic        cpu_wr = 1'b0;
   logic [13:0] cpu_addr = 14'h0000;
   logic [15:0] cpu_wdata = 16'h0000;
   logic [15:0] cpu_rdata;
   logic        cpu_ack;
   logic        in_valid = 1'b0;
   logic [4:0]  in_stream = 5'h00;
   logic [7:0]  in_chan = 8'h00;
   logic [1:0]  in_rate = 2'h0;
   logic [7:0]  in_octet = 8'h00;
   logic        store_valid;
   logic [4:0]  store_stream;
   logic [7:0]  store_chan;
   logic [7:0]  store_octet;
   logic        out_valid = 1'b0;
   logic        out_msg_mode = 1'b0;
   logic [7:0]  out_data_octet;
   logic [7:0]  out_msg_octet = 8'h00;
   logic [4:0]  entry = 5'h00;
   logic        tx_valid;
   logic [7:0]  tx_octet;
   logic [4:0]  rd_stream = 5'h00;
   logic [7:0]  rd_chan = 8'h00;
   logic [11:0] fr [0:31];
   logic [7:0]  em [0:8191];
   int          n_errors = 0;
   int          n_compared = 0;

   always #2.5 mclk = ~mclk;

   pcmx_quad_law DUT (.mclk(mclk), .rst(rst), .cpu_cs(cpu_cs), .cpu_wr(cpu_wr),
      .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack),
      .in_valid(in_valid), .in_stream(in_stream), .in_chan(in_chan), .in_rate(in_rate),
      .in_octet(in_octet), .store_valid(store_valid), .store_stream(store_stream),
      .store_chan(store_chan), .store_octet(store_octet), .out_valid(out_valid),
      .out_msg_mode(out_msg_mode), .out_data_octet(out_data_octet),
      .out_msg_octet(out_msg_octet), .conn_mem_upper_entry(entry), .tx_valid(tx_valid),
      .tx_octet(tx_octet));

   pcmx_far_model far (.mclk(mclk), .store_valid(store_valid), .store_stream(store_stream),
      .store_chan(store_chan), .store_octet(store_octet), .rd_stream(rd_stream),
      .rd_chan(rd_chan), .rd_octet(out_data_octet));

   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
         n_errors++;
      end
   endtask

   // Inversion that each coding applies to the raw code, voice or data.
   function automatic logic [7:0] vm(input logic dat, input logic [1:0] c);
      logic [7:0] v [4] = '{8'h55, 8'hff, 8'h00, 8'h80};
      logic [7:0] d [4] = '{8'h00, 8'h55, 8'haa, 8'hff};
      return dat ? d[c] : v[c];
   endfunction

   task automatic bus(input logic wr, input logic [13:0] a, input logic [15:0] d,
                      input logic [15:0] exp);
      @(posedge mclk);
      cpu_cs <= 1'b1;
      cpu_wr <= wr;
      cpu_addr <= a;
      cpu_wdata <= d;
      @(posedge mclk);
      cpu_cs <= 1'b0;
      @(posedge mclk);
      chk("cpu_ack", 16'h0001, {15'h0000, cpu_ack});
      if (!wr) begin
         chk("cpu_rdata", exp, cpu_rdata);
      end
   endtask

   task automatic set_force(input logic [4:0] s, input logic [15:0] d);
      fr[s] = d[11:0];
      bus(1'b1, pcmx_pkg::QFC_BASE + 14'(s), d, 16'h0000);
      bus(1'b0, pcmx_pkg::QFC_BASE + 14'(s), 16'h0000, {4'h0, d[11:0]});
   endtask

   task automatic send_in(input logic [4:0] s, input logic [7:0] c, input logic [7:0] o);
      logic [1:0] r;
      logic [2:0] q;
      logic [7:0] e;
      r = s[1:0];
      q = 3'(c >> (3 + r)) & 3'h3;
      e = o;
      if (fr[s][3*q+2]) begin
         if (fr[s][3*q+1]) e[7] = fr[s][3*q];
         else e[0] = fr[s][3*q];
      end
      em[{s, c}] = e;
      @(posedge mclk);
      in_valid <= 1'b1;
      in_stream <= s;
      in_chan <= c;
      in_rate <= r;
      in_octet <= o;
      @(posedge mclk);
      in_valid <= 1'b0;
      @(posedge mclk);
      chk("store_valid", 16'h0001, {15'h0000, store_valid});
      chk("store_octet", {8'h00, e}, {8'h00, store_octet});
      chk("store_where", {3'h0, s, c}, {3'h0, store_stream, store_chan});
   endtask

   task automatic send_out(input logic [4:0] e, input logic m, input logic [4:0] s,
                           input logic [7:0] c, input logic [7:0] mo);
      logic [7:0] x;
      logic [7:0] y;
      x = m ? mo : em[{s, c}];
      y = x ^ vm(e[4], e[3:2]) ^ vm(e[4], e[1:0]);
      @(posedge mclk);
      out_valid <= 1'b1;
      out_msg_mode <= m;
      out_msg_octet <= mo;
      entry <= e;
      rd_stream <= s;
      rd_chan <= c;
      @(posedge mclk);
      out_valid <= 1'b0;
      @(posedge mclk);
      chk("tx_valid", 16'h0001, {15'h0000, tx_valid});
      if (e[4] || e[2] == e[0]) begin
         chk("tx_octet", {8'h00, y}, {8'h00, tx_octet});
      end else begin
         // A change between the two laws keeps the sign of the sample.
         chk("tx_sign", {15'h0000, x[7]}, {15'h0000, tx_octet[7]});
      end
   endtask

   initial begin
      #100000;
      n_errors++;
      final_report();
   end

   initial begin
      logic [4:0] s;
      logic [7:0] c;
      void'($urandom(32'h0ad6));
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      chk("idle_valids", 16'h0000, {14'h0000, store_valid, tx_valid});
      for (int n = 0; n < 32; n++) begin
         fr[n] = 12'h000;
         bus(1'b0, pcmx_pkg::QFC_BASE + 14'(n), 16'h0000, 16'h0000);
      end
      bus(1'b1, pcmx_pkg::STAT_ADDR, 16'hffff, 16'h0000);
      bus(1'b0, pcmx_pkg::STAT_ADDR, 16'h0000, 16'h0000);
      bus(1'b0, 14'h0200, 16'h0000, 16'h0000);
      // Write then read back on consecutive edges, as the port allows.
      fr[3] = 12'he00;
      @(posedge mclk);
      cpu_cs <= 1'b1;
      cpu_wr <= 1'b1;
      cpu_addr <= pcmx_pkg::QFC_BASE + 14'h0003;
      cpu_wdata <= 16'h5e00;
      @(posedge mclk);
      cpu_wr <= 1'b0;
      @(posedge mclk);
      chk("b2b_ack", 16'h0001, {15'h0000, cpu_ack});
      cpu_cs <= 1'b0;
      @(posedge mclk);
      chk("b2b_rdata", 16'h0e00, cpu_rdata);
      // Every force code in every quadrant, at both edges of each quadrant.
      for (int k = 0; k < 8; k++) begin
         for (int q = 0; q < 4; q++) begin
            set_force(5'h05, 16'hf000 | (16'(k) << (3 * q)));
            send_in(5'h05, 8'(q * 16), 8'h5a);
            send_in(5'h05, 8'(q * 16 + 15), 8'ha5);
         end
      end
      send_out(5'h12, 1'b0, 5'h05, 8'h00, 8'h00);
      send_out(5'h12, 1'b1, 5'h05, 8'h00, 8'h12);
      for (int i = 0; i < 300; i++) begin
         s = 5'($urandom % 32);
         c = 8'($urandom % (32 << s[1:0]));
         if (i % 8 == 0) set_force(s, 16'($urandom));
         send_in(s, c, 8'($urandom));
         send_out(5'($urandom), 1'b0, s, c, 8'h00);
         send_out(5'($urandom), 1'b1, s, c, 8'($urandom));
      end
      // A reset in mid-run clears the outputs and every force register.
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      chk("reset_outputs", 16'h0000, {tx_octet, store_octet});
      for (int n = 0; n < 32; n++) begin
         fr[n] = 12'h000;
      end
      bus(1'b0, pcmx_pkg::QFC_BASE + 14'h0005, 16'h0000, 16'h0000);
      bus(1'b0, pcmx_pkg::STAT_ADDR, 16'h0000, 16'h0000);
      send_in(5'h05, 8'h00, 8'h5a);
      final_report();
   end
endmodule // testbench
